//--- rtl/hsf_pkg.sv
// constants, field positions and carrier types of the hot-swap status flag bank
// Operation
// R1 - output high voltage alert latches bit 6
// R2 - output low voltage alert latches bit 5
// R3 - reserved bits of all five registers read zero
// R4 - timed overcurrent trip latches bit 7, gate off
// R5 - current above warning limit latches bit 5
// R6 - high limit pin comparator latches bit 7
// R7 - input high voltage alert latches bit 6
// R8 - input low voltage alert latches bit 5
// R9 - low limit pin comparator latches bit 4
// R10 - input power alert latches bit 0
// R11 - overtemperature trip latches bit 7
// R12 - overtemperature alert latches bit 6
// R13 - bad command code latches bit 7
// R14 - all five registers reset to zero
// R15 - output voltage summary follows output voltage flags
// R16 - communication fault flags stay latched
// R17 - flags hold until cleared, re-set if persisting
package hsf_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int HSF_NUM_REGS = 5;
    localparam int HSF_DW = 8;
    localparam logic [7:0] HSF_CMD_VOUT = 8'h7a;
    localparam logic [7:0] HSF_CMD_IOUT = 8'h7b;
    localparam logic [7:0] HSF_CMD_INPUT = 8'h7c;
    localparam logic [7:0] HSF_CMD_TEMP = 8'h7d;
    localparam logic [7:0] HSF_CMD_CML = 8'h7e;
    localparam logic [7:0] HSF_RESET_VAL = 8'h00;

    // register indices into the flag array
    localparam logic [2:0] HSF_IDX_VOUT = 3'h0;
    localparam logic [2:0] HSF_IDX_IOUT = 3'h1;
    localparam logic [2:0] HSF_IDX_INPUT = 3'h2;
    localparam logic [2:0] HSF_IDX_TEMP = 3'h3;
    localparam logic [2:0] HSF_IDX_CML = 3'h4;
    localparam logic [2:0] HSF_IDX_NONE = 3'h7;

    // ****************************************
    // field positions
    // ****************************************
    localparam int HSF_VOUT_HI_BIT = 6;
    localparam int HSF_VOUT_LO_BIT = 5;
    localparam int HSF_IOUT_TRIP_BIT = 7;
    localparam int HSF_IOUT_ALERT_BIT = 5;
    localparam int HSF_VIN_PIN_HI_BIT = 7;
    localparam int HSF_VIN_HI_BIT = 6;
    localparam int HSF_VIN_LO_BIT = 5;
    localparam int HSF_VIN_PIN_LO_BIT = 4;
    localparam int HSF_PWR_BIT = 0;
    localparam int HSF_OT_TRIP_BIT = 7;
    localparam int HSF_OT_ALERT_BIT = 6;
    localparam int HSF_CML_BADCMD_BIT = 7;
    localparam int HSF_CML_DATA_BIT = 6;
    localparam int HSF_CML_PEC_BIT = 5;
    localparam int HSF_CML_OTHER_BIT = 1;

    // implemented bits per register, index 0 rightmost; the rest read zero
    localparam logic [HSF_NUM_REGS-1:0][7:0] HSF_REG_MASK = {
        8'he2, 8'hc0, 8'hf1, 8'ha0, 8'h60
    };

    // ****************************************
    // carrier types
    // ****************************************
    // condition levels from the monitor and protocol logic, same clock
    typedef struct packed {
        logic output_high_voltage_alert;
        logic output_low_voltage_alert;
        logic load_current_over;
        logic load_timer_expired;
        logic load_current_alert;
        logic input_high_voltage_alert;
        logic input_low_voltage_alert;
        logic input_power_alert;
        logic overtemperature_trip;
        logic overtemperature_alert;
        logic bad_command_flag;
        logic bad_data_flag;
        logic pec_fail_flag;
        logic comm_other_flag;
    } hsf_events_t;

    // status read request from the serial command decoder
    typedef struct packed {
        logic req;
        logic [7:0] cmd;
    } hsf_rd_req_t;

    // status read answer
    typedef struct packed {
        logic ack;
        logic unmapped;
        logic [7:0] data;
    } hsf_rd_rsp_t;

    // command code to flag register index, HSF_IDX_NONE when unmapped
    function automatic logic [2:0] hsf_cmd_index(input logic [7:0] cmd);
        logic [2:0] idx;
        idx = HSF_IDX_NONE;
        unique case (cmd)
            HSF_CMD_VOUT: idx = HSF_IDX_VOUT;
            HSF_CMD_IOUT: idx = HSF_IDX_IOUT;
            HSF_CMD_INPUT: idx = HSF_IDX_INPUT;
            HSF_CMD_TEMP: idx = HSF_IDX_TEMP;
            HSF_CMD_CML: idx = HSF_IDX_CML;
            default: idx = HSF_IDX_NONE;
        endcase
        return idx;
    endfunction

endpackage

//--- rtl/hsf_flag_latch.sv
// one byte of sticky status flags with masked reserved bits
`timescale 1ns/10ps
`default_nettype none
module hsf_flag_latch
    import hsf_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] MASK = '1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] set_in,
    input wire logic clear_in,
    output logic [W-1:0] flags
);

    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // ****************************************
    // latch
    // ****************************************
    // a set in the clear cycle wins, reserved bits never store
    assign flags_nxt = ((flags_r & ~{W{clear_in}}) | set_in) & MASK; // R17 R3
    assign flags = flags_r;

    // synchronous reset to all zeros
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_r <= W'(HSF_RESET_VAL); // R14
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    reserved_bits_zero_a: assert property ((flags_r & ~MASK) == '0) // R3
        else $error("reserved flag bit set");
    set_beats_clear_a: assert property ((|(set_in & MASK)) |=> ((flags_r & $past(set_in & MASK)) == $past(set_in & MASK))) // R17
        else $error("flag set was lost");
    flag_holds_a: assert property (!clear_in |=> ((flags_r & $past(flags_r)) == $past(flags_r))) // R16
        else $error("latched flag dropped without clear");

endmodule
`default_nettype wire

//--- rtl/hsf_status_bank.sv
// hot-swap status flag bank: sticky fault and warning bytes read by command code
`timescale 1ns/10ps
`default_nettype none
module hsf_status_bank
    import hsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire hsf_events_t events,
    input wire logic high_limit_pin,
    input wire logic low_limit_pin,
    input wire logic clear_faults,
    input wire hsf_rd_req_t rd_req,
    output hsf_rd_rsp_t rd_rsp,
    output logic gate_off,
    output logic output_voltage_summary
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic high_meta_r;
    logic high_sync_r;
    logic low_meta_r;
    logic low_sync_r;

    // two flops per comparator pin, first flop read only by the second
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            high_meta_r <= 1'b0;
            high_sync_r <= 1'b0;
            low_meta_r <= 1'b0;
            low_sync_r <= 1'b0;
        end else begin
            high_meta_r <= high_limit_pin;
            high_sync_r <= high_meta_r;
            low_meta_r <= low_limit_pin;
            low_sync_r <= low_meta_r;
        end
    end

    // ****************************************
    // read decode
    // ****************************************
    logic [2:0] rd_idx;
    logic rd_hit;
    logic rd_miss;
    logic [HSF_NUM_REGS-1:0][7:0] flags;
    logic [7:0] rd_sel;

    assign rd_idx = hsf_cmd_index(rd_req.cmd);
    assign rd_hit = rd_req.req && (rd_idx != HSF_IDX_NONE);
    assign rd_miss = rd_req.req && (rd_idx == HSF_IDX_NONE);
    // unmapped codes answer zero
    assign rd_sel = rd_hit ? flags[rd_idx] : HSF_RESET_VAL;

    // ****************************************
    // set vectors
    // ****************************************
    logic load_trip;
    logic cmd_fault;
    logic [HSF_NUM_REGS-1:0][7:0] set_vec;

    // timed overcurrent: limit reached and the timer has run out
    assign load_trip = events.load_current_over && events.load_timer_expired; // R4
    // a bad code seen by the decoder or an unmapped status read
    assign cmd_fault = events.bad_command_flag || rd_miss; // R13

    // output voltage flags
    always_comb begin
        set_vec[HSF_IDX_VOUT] = HSF_RESET_VAL;
        set_vec[HSF_IDX_VOUT][HSF_VOUT_HI_BIT] = events.output_high_voltage_alert; // R1
        set_vec[HSF_IDX_VOUT][HSF_VOUT_LO_BIT] = events.output_low_voltage_alert; // R2
    end

    // output current flags
    always_comb begin
        set_vec[HSF_IDX_IOUT] = HSF_RESET_VAL;
        set_vec[HSF_IDX_IOUT][HSF_IOUT_TRIP_BIT] = load_trip; // R4
        set_vec[HSF_IDX_IOUT][HSF_IOUT_ALERT_BIT] = events.load_current_alert; // R5
    end

    // input supply flags, pin comparators come through the synchronisers
    always_comb begin
        set_vec[HSF_IDX_INPUT] = HSF_RESET_VAL;
        set_vec[HSF_IDX_INPUT][HSF_VIN_PIN_HI_BIT] = high_sync_r; // R6
        set_vec[HSF_IDX_INPUT][HSF_VIN_HI_BIT] = events.input_high_voltage_alert; // R7
        set_vec[HSF_IDX_INPUT][HSF_VIN_LO_BIT] = events.input_low_voltage_alert; // R8
        set_vec[HSF_IDX_INPUT][HSF_VIN_PIN_LO_BIT] = low_sync_r; // R9
        set_vec[HSF_IDX_INPUT][HSF_PWR_BIT] = events.input_power_alert; // R10
    end

    // temperature flags
    always_comb begin
        set_vec[HSF_IDX_TEMP] = HSF_RESET_VAL;
        set_vec[HSF_IDX_TEMP][HSF_OT_TRIP_BIT] = events.overtemperature_trip; // R11
        set_vec[HSF_IDX_TEMP][HSF_OT_ALERT_BIT] = events.overtemperature_alert; // R12
    end

    // communication flags
    always_comb begin
        set_vec[HSF_IDX_CML] = HSF_RESET_VAL;
        set_vec[HSF_IDX_CML][HSF_CML_BADCMD_BIT] = cmd_fault; // R13
        set_vec[HSF_IDX_CML][HSF_CML_DATA_BIT] = events.bad_data_flag; // R16
        set_vec[HSF_IDX_CML][HSF_CML_PEC_BIT] = events.pec_fail_flag; // R16
        set_vec[HSF_IDX_CML][HSF_CML_OTHER_BIT] = events.comm_other_flag; // R16
    end

    // ****************************************
    // flag registers
    // ****************************************
    // one sticky byte per register, reserved bits masked off
    for (genvar i = 0; i < HSF_NUM_REGS; i++) begin : g_reg
        hsf_flag_latch #(
            .W(HSF_DW),
            .MASK(HSF_REG_MASK[i])
        ) u_latch (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .set_in(set_vec[i]),
            .clear_in(clear_faults), // R17
            .flags(flags[i])
        );
    end

    // ****************************************
    // outputs
    // ****************************************
    hsf_rd_rsp_t rd_rsp_r;
    hsf_rd_rsp_t rd_rsp_nxt;
    logic gate_off_r;
    logic gate_off_nxt;
    logic summary_r;

    assign rd_rsp_nxt.ack = rd_req.req;
    assign rd_rsp_nxt.unmapped = rd_miss;
    assign rd_rsp_nxt.data = rd_sel;
    // gate drive stays off with the trip flag, same cycle
    assign gate_off_nxt = load_trip || (gate_off_r && !clear_faults); // R4

    // answer one cycle after the request, summary one cycle behind flags
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_rsp_r <= '0;
            gate_off_r <= 1'b0;
            summary_r <= 1'b0;
        end else begin
            rd_rsp_r <= rd_rsp_nxt;
            gate_off_r <= gate_off_nxt;
            summary_r <= |flags[HSF_IDX_VOUT]; // R15
        end
    end

    assign rd_rsp = rd_rsp_r;
    assign gate_off = gate_off_r;
    assign output_voltage_summary = summary_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // pin held high over two samples reaches the flag two cycles later
    sequence high_pin_seen;
        high_limit_pin ##1 high_limit_pin;
    endsequence
    sequence low_pin_seen;
        low_limit_pin ##1 low_limit_pin;
    endsequence
    // unmapped read; the answer and the latched command flag both follow one cycle later
    sequence miss_read;
        rd_req.req && (hsf_cmd_index(rd_req.cmd) == HSF_IDX_NONE);
    endsequence

    vout_high_latch_a: assert property (events.output_high_voltage_alert |=> flags[0][6]) // R1
        else $error("output high alert not latched");
    vout_low_latch_a: assert property (events.output_low_voltage_alert |=> flags[0][5]) // R2
        else $error("output low alert not latched");
    read_reserved_zero_a: assert property (rd_rsp_r.ack |-> ((rd_rsp_r.data & 8'h01) == 8'h00 || $past(rd_req.cmd) == HSF_CMD_INPUT)) // R3
        else $error("reserved bit 0 read as one");
    load_trip_latch_a: assert property (load_trip |=> (flags[1][7] && gate_off_r)) // R4
        else $error("overcurrent trip not latched with gate off");
    gate_off_hold_a: assert property ((gate_off_r && !clear_faults) |=> gate_off_r) // R4
        else $error("gate drive released without clear");
    current_alert_latch_a: assert property (events.load_current_alert |=> flags[1][5]) // R5
        else $error("current alert not latched");
    high_pin_latch_a: assert property (high_pin_seen |-> ##2 flags[2][7]) // R6
        else $error("high limit pin not latched");
    vin_high_latch_a: assert property (events.input_high_voltage_alert |=> flags[2][6]) // R7
        else $error("input high alert not latched");
    vin_low_latch_a: assert property (events.input_low_voltage_alert |=> flags[2][5]) // R8
        else $error("input low alert not latched");
    low_pin_latch_a: assert property (low_pin_seen |-> ##2 flags[2][4]) // R9
        else $error("low limit pin not latched");
    power_alert_latch_a: assert property (events.input_power_alert |=> (flags[2][0] && flags[2][3:1] == 3'h0)) // R10
        else $error("power alert wrong");
    ot_trip_latch_a: assert property (events.overtemperature_trip |=> flags[3][7]) // R11
        else $error("overtemperature trip not latched");
    ot_alert_latch_a: assert property (events.overtemperature_alert |=> flags[3][6]) // R12
        else $error("overtemperature alert not latched");
    bad_cmd_read_a: assert property (miss_read |=> (rd_rsp_r.unmapped && rd_rsp_r.data == 8'h00 && flags[4][7])) // R13
        else $error("unmapped read not flagged");
    reset_zero_a: assert property (@(posedge clk_sys) $past(sys_rst) |-> (flags == '0 && !gate_off_r)) // R14
        else $error("flags not zero after reset");
    summary_follows_a: assert property (events.output_low_voltage_alert |=> ##1 summary_r) // R15
        else $error("output voltage summary not raised");
    cml_hold_a: assert property ((flags[4][5] && !clear_faults) |=> flags[4][5]) // R16
        else $error("pec flag dropped");
    clear_quiet_a: assert property ((clear_faults && set_vec == '0) |=> flags == '0) // R17
        else $error("clear left flags set");
    read_data_a: assert property ((rd_req.req && rd_req.cmd == HSF_CMD_TEMP) |=> rd_rsp_r.data == $past(flags[3])) // R17
        else $error("read returned wrong byte");

    // ****************************************
    // cause checks
    // ****************************************
    // a flag rises only when its own cause stood one cycle before
    vout_high_cause_a: assert property ($rose(flags[HSF_IDX_VOUT][HSF_VOUT_HI_BIT]) // R1
        |-> $past(events.output_high_voltage_alert))
        else $error("output high flag without cause");
    vout_low_cause_a: assert property ($rose(flags[HSF_IDX_VOUT][HSF_VOUT_LO_BIT]) // R2
        |-> $past(events.output_low_voltage_alert))
        else $error("output low flag without cause");
    trip_cause_a: assert property ($rose(flags[HSF_IDX_IOUT][HSF_IOUT_TRIP_BIT]) // R4
        |-> $past(events.load_current_over && events.load_timer_expired))
        else $error("trip flag without timed overcurrent");
    current_alert_cause_a: assert property ($rose(flags[HSF_IDX_IOUT][HSF_IOUT_ALERT_BIT]) // R5
        |-> $past(events.load_current_alert))
        else $error("current alert flag without cause");
    high_pin_cause_a: assert property ($rose(flags[HSF_IDX_INPUT][HSF_VIN_PIN_HI_BIT]) // R6
        |-> $past(high_sync_r))
        else $error("high pin flag without pin");
    vin_high_cause_a: assert property ($rose(flags[HSF_IDX_INPUT][HSF_VIN_HI_BIT]) // R7
        |-> $past(events.input_high_voltage_alert))
        else $error("input high flag without cause");
    vin_low_cause_a: assert property ($rose(flags[HSF_IDX_INPUT][HSF_VIN_LO_BIT]) // R8
        |-> $past(events.input_low_voltage_alert))
        else $error("input low flag without cause");
    low_pin_cause_a: assert property ($rose(flags[HSF_IDX_INPUT][HSF_VIN_PIN_LO_BIT]) // R9
        |-> $past(low_sync_r))
        else $error("low pin flag without pin");
    power_cause_a: assert property ($rose(flags[HSF_IDX_INPUT][HSF_PWR_BIT]) // R10
        |-> $past(events.input_power_alert))
        else $error("power flag without cause");
    ot_trip_cause_a: assert property ($rose(flags[HSF_IDX_TEMP][HSF_OT_TRIP_BIT]) // R11
        |-> $past(events.overtemperature_trip))
        else $error("overtemperature trip flag without cause");
    ot_alert_cause_a: assert property ($rose(flags[HSF_IDX_TEMP][HSF_OT_ALERT_BIT]) // R12
        |-> $past(events.overtemperature_alert))
        else $error("overtemperature alert flag without cause");
    bad_cmd_cause_a: assert property ($rose(flags[HSF_IDX_CML][HSF_CML_BADCMD_BIT]) // R13
        |-> $past(events.bad_command_flag || rd_miss))
        else $error("command flag without bad code");
    bad_data_cause_a: assert property ($rose(flags[HSF_IDX_CML][HSF_CML_DATA_BIT]) // R16
        |-> $past(events.bad_data_flag))
        else $error("bad data flag without cause");
    pec_cause_a: assert property ($rose(flags[HSF_IDX_CML][HSF_CML_PEC_BIT]) // R16
        |-> $past(events.pec_fail_flag))
        else $error("pec flag without cause");
    comm_other_cause_a: assert property ($rose(flags[HSF_IDX_CML][HSF_CML_OTHER_BIT]) // R16
        |-> $past(events.comm_other_flag))
        else $error("comm other flag without cause");
    gate_off_cause_a: assert property ($rose(gate_off_r) // R4
        |-> $past(events.load_current_over && events.load_timer_expired))
        else $error("gate drive off without timed overcurrent");

    // ****************************************
    // read, gate and pin checks
    // ****************************************
    // every mapped read except the temperature one, checked above, returns its byte as it stood at the request
    vout_read_a: assert property ((rd_req.req && rd_req.cmd == HSF_CMD_VOUT) // R14
        |=> (rd_rsp_r.data == $past(flags[HSF_IDX_VOUT]) && !rd_rsp_r.unmapped))
        else $error("output voltage byte misread");
    iout_read_a: assert property ((rd_req.req && rd_req.cmd == HSF_CMD_IOUT) // R14
        |=> (rd_rsp_r.data == $past(flags[HSF_IDX_IOUT]) && !rd_rsp_r.unmapped))
        else $error("output current byte misread");
    input_read_a: assert property ((rd_req.req && rd_req.cmd == HSF_CMD_INPUT) // R14
        |=> (rd_rsp_r.data == $past(flags[HSF_IDX_INPUT]) && !rd_rsp_r.unmapped))
        else $error("input supply byte misread");
    cml_read_a: assert property ((rd_req.req && rd_req.cmd == HSF_CMD_CML) // R14
        |=> (rd_rsp_r.data == $past(flags[HSF_IDX_CML]) && !rd_rsp_r.unmapped))
        else $error("communication byte misread");
    // one answer per request, none without
    ack_pulse_a: assert property (rd_req.req |=> rd_rsp_r.ack) // R14
        else $error("read not answered");
    ack_idle_a: assert property (!rd_req.req |=> !rd_rsp_r.ack) // R14
        else $error("answer without read");
    // communication faults other than the command one latch too
    data_latch_a: assert property (events.bad_data_flag // R16
        |=> flags[HSF_IDX_CML][HSF_CML_DATA_BIT])
        else $error("bad data not latched");
    pec_latch_a: assert property (events.pec_fail_flag // R16
        |=> flags[HSF_IDX_CML][HSF_CML_PEC_BIT])
        else $error("pec failure not latched");
    other_latch_a: assert property (events.comm_other_flag // R16
        |=> flags[HSF_IDX_CML][HSF_CML_OTHER_BIT])
        else $error("comm other fault not latched");
    // summary is the output voltage byte one cycle late
    summary_exact_a: assert property (!$past(sys_rst) // R15
        |-> summary_r == $past(|flags[HSF_IDX_VOUT]))
        else $error("summary not one cycle behind flags");
    // gate drive tracks the trip flag and is released by clear
    gate_trip_a: assert property (gate_off_r == flags[HSF_IDX_IOUT][HSF_IOUT_TRIP_BIT]) // R4
        else $error("gate drive and trip flag differ");
    gate_release_a: assert property ((gate_off_r && clear_faults && !load_trip) // R17
        |=> !gate_off_r)
        else $error("gate drive not released by clear");
    // pin synchroniser outputs see the comparators exactly two cycles late
    high_sync_a: assert property ((!$past(sys_rst) && !$past(sys_rst, 2)) // R6
        |-> high_sync_r == $past(high_limit_pin, 2))
        else $error("high limit pin not two cycles late");
    low_sync_a: assert property ((!$past(sys_rst) && !$past(sys_rst, 2)) // R9
        |-> low_sync_r == $past(low_limit_pin, 2))
        else $error("low limit pin not two cycles late");

endmodule
`default_nettype wire

//--- testbench/hsf_host_model.sv
// host-side model: reads status bytes by command code and pulses the fault clear
`timescale 1ns/10ps
`default_nettype none
module hsf_host_model
    import hsf_pkg::*;
(
    input wire logic clk_sys,
    output var hsf_rd_req_t rd_req,
    input wire hsf_rd_rsp_t rd_rsp,
    output var logic clear_faults
);
    // idle bus at time zero
    initial begin
        rd_req = {1'b0, 8'h5a};
        clear_faults = 1'b0;
    end

    // one read: request for a single edge, then a bounded wait for the answer
    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data, output logic unm);
        data = 8'hxx;
        unm = 1'bx;
        @(negedge clk_sys);
        rd_req = {1'b1, cmd};
        @(negedge clk_sys);
        rd_req = {1'b0, ~cmd}; // released code is the inverse, never a stale one
        for (int n = 0; n < 4 && rd_rsp.ack !== 1'b1; n++) begin
            @(negedge clk_sys);
        end
        if (rd_rsp.ack === 1'b1) begin
            data = rd_rsp.data;
            unm = rd_rsp.unmapped;
        end
    endtask

    // fault clear pulse, one cycle wide
    task automatic clear();
        @(negedge clk_sys);
        clear_faults = 1'b1;
        @(negedge clk_sys);
        clear_faults = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench of the status flag bank with a host-side reader
`timescale 1ns/10ps
`default_nettype none
module testbench
    import hsf_pkg::*;
();
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    hsf_events_t ev = '0;
    logic hi_pin = 1'b0;
    logic lo_pin = 1'b0;
    hsf_rd_req_t rd_req;
    hsf_rd_rsp_t rd_rsp;
    logic clear_faults;
    logic gate_off;
    logic summary;
    logic [7:0] d;
    logic u;
    int errors = 0;
    int check_count = 0;
    // register and byte expected after each single event, indexed by event bit
    logic [7:0] tcmd [14] = '{8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h7d, 8'h7d, 8'h7c,
        8'h7c, 8'h7c, 8'h7b, 8'h7b, 8'h7b, 8'h7a, 8'h7a};
    logic [7:0] tval [14] = '{8'h02, 8'h20, 8'h40, 8'h80, 8'h40, 8'h80, 8'h01,
        8'h20, 8'h40, 8'h20, 8'h00, 8'h00, 8'h20, 8'h40};
    logic [7:0] mask [5] = '{8'h60, 8'ha0, 8'hf1, 8'hc0, 8'he2};

    // clock and the two modules
    always #12.5 clk_sys = ~clk_sys;
    hsf_status_bank hsf_status_bank_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .events(ev),
        .high_limit_pin(hi_pin), .low_limit_pin(lo_pin), .clear_faults(clear_faults),
        .rd_req(rd_req), .rd_rsp(rd_rsp), .gate_off(gate_off),
        .output_voltage_summary(summary));
    hsf_host_model hsf_host_model_i (.clk_sys(clk_sys), .rd_req(rd_req), .rd_rsp(rd_rsp),
        .clear_faults(clear_faults));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_reg(input logic [7:0] cmd, input logic [7:0] exp);
        hsf_host_model_i.read_reg(cmd, d, u);
        check(d, exp);
        check({7'h00, u}, 8'h00);
    endtask
    task automatic pulse(input int idx);
        @(negedge clk_sys);
        ev[idx] = 1'b1;
        @(negedge clk_sys);
        ev = '0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values();
        for (int i = 0; i < 5; i++) begin
            expect_reg(8'h7a + 8'(i), 8'h00);
        end
        check({7'h00, gate_off}, 8'h00);
        check({7'h00, summary}, 8'h00);
    endtask
    task automatic t_single_events();
        for (int i = 0; i < 14; i++) begin
            pulse(i);
            repeat (2) @(negedge clk_sys);
            expect_reg(tcmd[i], tval[i]);
            expect_reg(tcmd[i], tval[i]);
            check({7'h00, summary}, {7'h00, tcmd[i] == 8'h7a});
            check({7'h00, gate_off}, 8'h00);
            hsf_host_model_i.clear();
            expect_reg(tcmd[i], 8'h00);
            check({7'h00, summary}, 8'h00);
        end
    endtask
    task automatic t_timed_trip();
        @(negedge clk_sys);
        ev.load_current_over = 1'b1;
        ev.load_timer_expired = 1'b1;
        @(negedge clk_sys);
        ev = '0;
        check({7'h00, gate_off}, 8'h01);
        expect_reg(8'h7b, 8'h80);
        hsf_host_model_i.clear();
        check({7'h00, gate_off}, 8'h00);
        expect_reg(8'h7b, 8'h00);
    endtask
    task automatic t_pins();
        for (int j = 0; j < 2; j++) begin
            @(negedge clk_sys);
            {hi_pin, lo_pin} = (j == 0) ? 2'b10 : 2'b01;
            repeat (4) @(negedge clk_sys);
            {hi_pin, lo_pin} = 2'b00;
            repeat (3) @(negedge clk_sys);
            expect_reg(8'h7c, (j == 0) ? 8'h80 : 8'h10);
            hsf_host_model_i.clear();
        end
    endtask
    task automatic t_all_then_reset();
        @(negedge clk_sys);
        ev = '1;
        {hi_pin, lo_pin} = 2'b11;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            expect_reg(8'h7a + 8'(i), mask[i]);
        end
        hsf_host_model_i.clear();
        for (int i = 0; i < 5; i++) begin
            expect_reg(8'h7a + 8'(i), mask[i]);
        end
        check({7'h00, gate_off}, 8'h01);
        ev = '0;
        {hi_pin, lo_pin} = 2'b00;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_reset_values();
    endtask
    task automatic t_unmapped();
        hsf_host_model_i.read_reg(8'h7f, d, u);
        check(d, 8'h00);
        check({7'h00, u}, 8'h01);
        expect_reg(8'h7e, 8'h80);
        hsf_host_model_i.clear();
        hsf_host_model_i.read_reg(8'h79, d, u);
        check(d, 8'h00);
        check({7'h00, u}, 8'h01);
        expect_reg(8'h7e, 8'h80);
        hsf_host_model_i.clear();
    endtask

    // main sequence
    initial begin
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_reset_values();
        t_single_events();
        t_timed_trip();
        t_pins();
        t_unmapped();
        t_all_then_reset();
        report_and_stop();
    end

    // watchdog, far beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
